// >>> design/cli_init.sv
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module cli_init #(
   parameter int unsigned POWERON_CYCLES = cli_pkg::POWERON_CYC,
   parameter int unsigned SHORT_CYCLES = cli_pkg::SHORT_CYC,
   parameter int unsigned LONG_CYCLES = cli_pkg::LONG_CYC
) (
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   input wire cli_pkg::cli_ahb_req_t I_AHB,
   output cli_pkg::cli_ahb_rsp_t O_AHB,
   output logic O_BUSY,
   output logic O_DISPLAY_ON,
   output logic O_CURSOR_ON,
   output logic O_BLINK_ON
);
   import cli_pkg::*;

   typedef struct packed {
      cli_state_t state;
      logic [31:0] cnt;
      logic busy;
      cli_cfg_t cfg;
      logic [6:0] ac;
      logic pend;
      logic [3:0] hi;
      logic refused;
      logic wr_ph;
      logic [7:0] wa;
      cli_ahb_rsp_t rsp;
   } cli_regs_t;

   cli_regs_t r;
   cli_regs_t nxt;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [6:0] cli_step(input logic [6:0] ac, input logic up);
      cli_step = up ? ac + 7'h01 : ac - 7'h01;
   endfunction

   function automatic logic [31:0] cli_read(input cli_regs_t s, input logic [7:0] a);
      cli_read = 32'h0000_0000;
      unique case (a)
         OFS_STATUS: begin
            cli_read[ST_BUSY_BIT] = s.busy;
            cli_read[ST_DONE_BIT] = (s.state == ST_READY);
            cli_read[ST_PEND_BIT] = s.pend;
            cli_read[ST_REFUSED_BIT] = s.refused;
         end
         OFS_CONFIG: cli_read[7:0] = s.cfg;
         OFS_ADDR: cli_read[6:0] = s.ac;
         default: cli_read = 32'h0000_0000;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic go;
   logic register_select;
   logic [7:0] cmd;
   logic cmd_wr;
   logic addr_ph;

   always_comb begin
      nxt = r;
      go = 1'b0;
      register_select = 1'b0;
      cmd = 8'h00;
      addr_ph = I_AHB.hsel && I_AHB.hready && I_AHB.htrans[1];
      cmd_wr = r.wr_ph && (r.wa == OFS_CMD);
      nxt.rsp.hreadyout = 1'b1;
      nxt.rsp.hresp = 1'b0;
      if (r.cnt != 32'h0000_0000) begin
         nxt.cnt = r.cnt - 32'h0000_0001;
      end

      // internal power-on steps, no host involvement
      unique case (r.state)
         ST_CLEAR: begin
            nxt.ac = RST_AC;
            nxt.cfg.incr = RST_INCR;
            nxt.state = ST_FUNC;
         end
         ST_FUNC: begin
            nxt.cfg.bus_width_select = RST_BUS_WIDTH;
            nxt.cfg.lines = RST_LINES;
            nxt.cfg.font = RST_FONT;
            nxt.state = ST_DISP;
         end
         ST_DISP: begin
            nxt.cfg.display = RST_DISPLAY;
            nxt.cfg.cursor = RST_CURSOR;
            nxt.cfg.blink = RST_BLINK;
            nxt.state = ST_ENTRY;
         end
         ST_ENTRY: begin
            nxt.cfg.incr = RST_INCR;
            nxt.cfg.shift = RST_SHIFT;
            nxt.state = ST_WAIT;
         end
         ST_WAIT: begin
            if (nxt.cnt == 32'h0000_0000) begin
               nxt.state = ST_READY;
            end
         end
         ST_READY: begin
         end
      endcase

      // host instruction port
      if (cmd_wr) begin
         if (r.busy) begin
            nxt.refused = 1'b1;
         end else if (r.cfg.bus_width_select) begin
            go = 1'b1;
            cmd = I_AHB.hwdata[7:0];
            register_select = I_AHB.hwdata[CMD_REGISTER_SELECT_BIT];
         end else if (!r.pend) begin
            nxt.pend = 1'b1;
            nxt.hi = I_AHB.hwdata[7:4];
         end else begin
            nxt.pend = 1'b0;
            go = 1'b1;
            cmd = {r.hi, I_AHB.hwdata[7:4]};
            register_select = I_AHB.hwdata[CMD_REGISTER_SELECT_BIT];
         end
      end

      if (go) begin
         nxt.cnt = SHORT_CYCLES;
         if (register_select) begin
            nxt.ac = cli_step(r.ac, r.cfg.incr);
         end else begin
            unique casez (cmd)
               8'b1???_????: nxt.ac = cmd[6:0];
               8'b01??_????: nxt.ac = {1'b0, cmd[5:0]};
               8'b001?_????: begin
                  nxt.cfg.bus_width_select = cmd[4];
                  // on a narrow wiring the low lines float: take line/font from next nibble
                  if (r.cfg.bus_width_select && !cmd[4]) begin
                     nxt.pend = 1'b1;
                     nxt.hi = cmd[7:4];
                  end else begin
                     nxt.cfg.lines = cmd[3];
                     nxt.cfg.font = cmd[2];
                  end
               end
               8'b0001_????: begin
                  if (!cmd[3]) begin
                     nxt.ac = cli_step(r.ac, cmd[2]);
                  end
               end
               8'b0000_1???: begin
                  nxt.cfg.display = cmd[2];
                  nxt.cfg.cursor = cmd[1];
                  nxt.cfg.blink = cmd[0];
               end
               8'b0000_01??: begin
                  nxt.cfg.incr = cmd[1];
                  nxt.cfg.shift = cmd[0];
               end
               8'b0000_001?: begin
                  nxt.ac = RST_AC;
                  nxt.cnt = LONG_CYCLES;
               end
               8'b0000_0001: begin
                  nxt.ac = RST_AC;
                  nxt.cfg.incr = RST_INCR;
                  nxt.cnt = LONG_CYCLES;
               end
               8'b0000_0000: begin
               end
            endcase
         end
      end

      // write-one-to-clear, but a new refusal in the same cycle wins
      if (r.wr_ph && (r.wa == OFS_STATUS) && I_AHB.hwdata[ST_REFUSED_BIT]
          && !(cmd_wr && r.busy)) begin
         nxt.refused = 1'b0;
      end

      // bus address phase; zero wait states so read data is ready in data phase
      nxt.wr_ph = addr_ph && I_AHB.hwrite;
      if (addr_ph) begin
         nxt.wa = I_AHB.haddr[7:0];
         if (!I_AHB.hwrite) begin
            nxt.rsp.hrdata = cli_read(r, I_AHB.haddr[7:0]);
         end
      end

      nxt.busy = (nxt.state != ST_READY) || (nxt.cnt != 32'h0000_0000);

      if (I_SYS_RST) begin
         nxt.state = ST_CLEAR;
         nxt.cnt = POWERON_CYCLES;
         nxt.busy = 1'b1;
         nxt.cfg = '{RST_BUS_WIDTH, RST_LINES, RST_FONT, RST_DISPLAY,
                     RST_CURSOR, RST_BLINK, RST_INCR, RST_SHIFT};
         nxt.ac = RST_AC;
         nxt.pend = 1'b0;
         nxt.hi = 4'h0;
         nxt.refused = 1'b0;
         nxt.wr_ph = 1'b0;
         nxt.wa = 8'h00;
         nxt.rsp = '{32'h0000_0000, 1'b1, 1'b0};
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS) begin
      r <= nxt;
   end

   assign O_AHB = r.rsp;
   assign O_BUSY = r.busy;
   assign O_DISPLAY_ON = r.cfg.display;
   assign O_CURSOR_ON = r.cfg.cursor;
   assign O_BLINK_ON = r.cfg.blink;

endmodule

// >>> design/cli_pkg.sv
// Summary of operation
// - after reset the block runs clear, function, display and entry steps unprompted.
// - busy indicator stays 1 through power-on initialisation, drops only when finished.
// - power-on busy period lasts 40 ms of system clock after reset release.
// - reset clears display, sets 8-bit bus, one line, 5x8 font.
// - after reset display, cursor and blink control bits are all 0.
// - after reset entry mode increments address by one, no display shift.
// - in 4-bit mode each byte crosses as two upper-line nibbles, high first.
// - no instruction is accepted while busy; host holds off until clear.
package cli_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned POWERON_MS = 40;
   localparam int unsigned SHORT_NS = 37000;
   localparam int unsigned LONG_NS = 1520000;
   localparam int unsigned POWERON_CYC = POWERON_MS * CLK_MHZ * 1000;
   // least times round up
   localparam int unsigned SHORT_CYC = (SHORT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned LONG_CYC = (LONG_NS * CLK_MHZ + 999) / 1000;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam logic [7:0] OFS_ADDR = 8'h0C;
   localparam int CMD_REGISTER_SELECT_BIT = 8;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_PEND_BIT = 2;
   localparam int ST_REFUSED_BIT = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_BUS_WIDTH = 1'b1;
   localparam logic RST_LINES = 1'b0;
   localparam logic RST_FONT = 1'b0;
   localparam logic RST_DISPLAY = 1'b0;
   localparam logic RST_CURSOR = 1'b0;
   localparam logic RST_BLINK = 1'b0;
   localparam logic RST_INCR = 1'b1;
   localparam logic RST_SHIFT = 1'b0;
   localparam logic [6:0] RST_AC = 7'h00;

   typedef enum {ST_CLEAR, ST_FUNC, ST_DISP, ST_ENTRY, ST_WAIT, ST_READY} cli_state_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } cli_ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } cli_ahb_rsp_t;

   typedef struct packed {
      logic bus_width_select;
      logic lines;
      logic font;
      logic display;
      logic cursor;
      logic blink;
      logic incr;
      logic shift;
   } cli_cfg_t;

endpackage

// >>> verification/cli_host_model.sv
`timescale 1ns/1ps
module cli_host_model (
   input wire logic i_clk,
   input wire cli_pkg::cli_ahb_rsp_t i_rsp,
   output cli_pkg::cli_ahb_req_t o_req
);
   import cli_pkg::*;
   logic [7:0] addr_r = 8'h00;
   logic [31:0] wdata_r = 32'h0000_0000;
   logic [1:0] trans_r = 2'h0;
   logic write_r = 1'b0;
   assign o_req = '{hsel: 1'b1, haddr: {24'h00_0000, addr_r}, htrans: trans_r,
      hwrite: write_r, hsize: 3'h2, hwdata: wdata_r, hready: i_rsp.hreadyout};
   // single word transfer; call just after a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      addr_r <= a;
      write_r <= w;
      trans_r <= 2'h2;
      @(posedge i_clk);
      while (!i_rsp.hreadyout) @(posedge i_clk);
      trans_r <= 2'h0;
      wdata_r <= d;
      @(posedge i_clk);
      while (!i_rsp.hreadyout) @(posedge i_clk);
      r = i_rsp.hrdata;
   endtask
endmodule

// >>> verification/cli_init_properties.sv
`timescale 1ns/1ps
module cli_init_properties #(
   parameter int unsigned POWERON_CYCLES = 50,
   parameter int unsigned SHORT_CYCLES = 8,
   parameter int unsigned LONG_CYCLES = 20
) (
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   input wire cli_pkg::cli_ahb_req_t I_AHB,
   input wire cli_pkg::cli_ahb_rsp_t O_AHB,
   input wire logic O_BUSY,
   input wire logic O_DISPLAY_ON,
   input wire logic O_CURSOR_ON,
   input wire logic O_BLINK_ON
);
   import cli_pkg::*;
   typedef struct packed {logic [31:0] cnt; logic [31:0] run;} cli_chk_t;
   cli_chk_t s_r;
   cli_chk_t s_nxt;
   logic take_w;
   logic [2:0] ctrl;
   assign take_w = I_AHB.hsel && I_AHB.hready && I_AHB.htrans[1] && I_AHB.hwrite
      && I_AHB.haddr[7:0] == OFS_CMD;
   assign ctrl = {O_DISPLAY_ON, O_CURSOR_ON, O_BLINK_ON};
   // cnt saturates just past the power-on window
   always_comb begin
      s_nxt = s_r;
      s_nxt.run = O_BUSY ? s_r.run + 32'h0000_0001 : 32'h0000_0000;
      if (I_SYS_RST) begin
         s_nxt.cnt = 32'h0000_0000;
      end else if (s_r.cnt <= POWERON_CYCLES) begin
         s_nxt.cnt = s_r.cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge I_CLK_SYS) begin
      s_r <= s_nxt;
   end
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SYS_RST);
   busy_hold_a: assert property (s_r.cnt < POWERON_CYCLES |-> O_BUSY)
      else $error("busy dropped early");
   busy_end_a: assert property (s_r.cnt == POWERON_CYCLES |-> !O_BUSY)
      else $error("busy too long");
   ctrl_off_a: assert property (s_r.cnt <= POWERON_CYCLES |-> ctrl == 3'h0)
      else $error("control bits set");
   ctrl_cause_a: assert property ($changed(ctrl) |-> $past(take_w, 2))
      else $error("control changed unasked");
   ctrl_busy_a: assert property ($changed(ctrl) |-> O_BUSY)
      else $error("command without busy");
   refuse_busy_a: assert property (take_w && O_BUSY ##1 O_BUSY |=> $stable(ctrl))
      else $error("command taken while busy");
   busy_len_a: assert property ($fell(O_BUSY) && s_r.cnt > POWERON_CYCLES
      |-> s_r.run == SHORT_CYCLES || s_r.run == LONG_CYCLES)
      else $error("busy length wrong");
   bus_okay_a: assert property (O_AHB.hreadyout && !O_AHB.hresp)
      else $error("bus answer not okay");
   cover property (s_r.cnt == POWERON_CYCLES);
   cover property ($changed(ctrl));
   cover property (take_w && O_BUSY ##1 O_BUSY);
endmodule
bind cli_init cli_init_properties #(.POWERON_CYCLES(POWERON_CYCLES),
   .SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) u_props (
   .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_AHB(I_AHB), .O_AHB(O_AHB),
   .O_BUSY(O_BUSY), .O_DISPLAY_ON(O_DISPLAY_ON), .O_CURSOR_ON(O_CURSOR_ON),
   .O_BLINK_ON(O_BLINK_ON));

// >>> verification/test_char_lcd_power_on_init.sv
`timescale 1ns/1ps
module test_char_lcd_power_on_init;
   import cli_pkg::*;
   // short counts keep the run brief
   localparam int unsigned P = 50;
   localparam int unsigned SC = 8;
   localparam int unsigned LC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   cli_ahb_req_t req;
   cli_ahb_rsp_t rsp;
   logic busy, disp, cur, blink;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [2:0] dcb;
   logic [1:0] nf, is;
   logic [6:0] ad;
   always #4 clk = ~clk;
   cli_host_model host (.i_clk(clk), .i_rsp(rsp), .o_req(req));
   cli_init #(.POWERON_CYCLES(P), .SHORT_CYCLES(SC), .LONG_CYCLES(LC)) i_dut (
      .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_AHB(req), .O_AHB(rsp), .O_BUSY(busy),
      .O_DISPLAY_ON(disp), .O_CURSOR_ON(cur), .O_BLINK_ON(blink));
   function automatic logic [31:0] exp_cfg(logic [1:0] n_f, logic [2:0] d, logic [1:0] i_s);
      return {24'h00_0000, 1'b0, n_f, d, i_s};
   endfunction
   // one data access steps the address counter by one in the entry direction
   function automatic logic [31:0] exp_ac(logic [6:0] a, logic up);
      return {25'h000_0000, up ? a + 7'h01 : a - 7'h01};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0000_0000, rd);
      chk(rd, exp);
   endtask
   // fixed wait after each nibble, no busy polling
   task automatic cmd(input logic [7:0] b, input int unsigned gap);
      host.xfer(1'b1, OFS_CMD, {24'h00_0000, b}, rd);
      repeat (gap) @(posedge clk);
   endtask
   // whole byte in 4-bit mode: high nibble, then low nibble with register_select
   task automatic nib2(input logic [7:0] b, input logic s, input int unsigned gap);
      host.xfer(1'b1, OFS_CMD, {24'h00_0000, b[7:4], 4'h0}, rd);
      host.xfer(1'b1, OFS_CMD, {23'h00_0000, s, b[3:0], 4'h0}, rd);
      repeat (gap) @(posedge clk);
   endtask
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(32'h1712e616));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rchk(OFS_STATUS, 32'h0000_0001);
      chk({31'h0000_0000, busy}, 32'h0000_0001);
      rchk(OFS_CONFIG, 32'h0000_0082);
      rchk(OFS_ADDR, 32'h0000_0000);
      cmd(8'h0C, 0);
      rchk(OFS_STATUS, 32'h0000_0009);
      host.xfer(1'b1, OFS_STATUS, 32'h0000_0008, rd);
      rchk(OFS_STATUS, 32'h0000_0001);
      rchk(8'h10 + 8'(4 * $urandom_range(59)), 32'h0000_0000);
      $display("done: power_on");
      repeat (P) @(posedge clk);
      rchk(OFS_STATUS, 32'h0000_0002);
      nf = 2'($urandom);
      cmd(8'h30, SC + 4);
      repeat (2) begin
         cmd(8'h20, SC + 4);
         cmd({nf, 6'h00}, SC + 4);
      end
      repeat (3) begin
         dcb = 3'($urandom);
         cmd(8'h00, SC + 4);
         cmd({1'b1, dcb, 4'h0}, SC + 4);
         chk({29'h0, disp, cur, blink}, {29'h0, dcb});
      end
      cmd(8'h00, SC + 4);
      cmd(8'h10, LC + 4);
      is = 2'($urandom);
      cmd(8'h00, SC + 4);
      cmd({2'b01, is, 4'h0}, SC + 4);
      rchk(OFS_CONFIG, exp_cfg(nf, dcb, is));
      $display("done: init_4bit");
      ad = 7'($urandom);
      nib2({1'b1, ad}, 1'b0, SC + 4);
      rchk(OFS_ADDR, {25'h000_0000, ad});
      nib2(8'($urandom), 1'b1, SC + 4);
      rchk(OFS_ADDR, exp_ac(ad, is[1]));
      nib2(8'h02, 1'b0, LC + 4);
      rchk(OFS_ADDR, 32'h0000_0000);
      $display("done: address");
      // second power-on in mid-run must restore every default
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({31'h0000_0000, busy}, 32'h0000_0001);
      rchk(OFS_CONFIG, 32'h0000_0082);
      rchk(OFS_ADDR, 32'h0000_0000);
      repeat (P) @(posedge clk);
      chk({31'h0000_0000, busy}, 32'h0000_0000);
      $display("done: reset_again");
      wrap_up();
   end
endmodule
